/* design/timer8_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef TIMER8_MAP_SVH
`define TIMER8_MAP_SVH
`define CTRL_OFFSET       12'h000
`define CMP_OFFSET        12'h004
`define DUTY_OFFSET       12'h008
`define STATUS_OFFSET     12'h00C
`define COUNT_OFFSET      12'h010
`define CTRL_MODE_LO      0
`define CTRL_RUN_BIT      3
`define CTRL_SRC_LO       4
`define CTRL_FF_BIT       7
`define CTRL_PSEL_BIT     8
`define CTRL_SLOW_BIT     9
`define STAT_MATCH_BIT    0
`define MODE_EVENT        2'h0
`define MODE_DIVIDER      2'h1
`define MODE_PWM          2'h2
`define SRC_DIV2048       3'h0
`define SRC_DIV128        3'h1
`define SRC_DIV32         3'h2
`define SRC_DIV8          3'h3
`define SRC_SLOW          3'h4
`define SRC_HALF          3'h5
`define SRC_FAST          3'h6
`define CTRL_RESET        10'h000
`define CMP_RESET         8'h00
`define DUTY_RESET        8'h00
`define COUNT_RESET       8'h00
`define COUNT_MAX         8'hFF
`define PRE_TAP_2048      10
`define PRE_TAP_128       6
`define PRE_TAP_32        4
`define PRE_TAP_8         2
`define PRE_TAP_HALF      0
`define SLOW_TAP_8        2
`endif

/* design/timer8_pkg.sv */
// types shared by the timer channel
package timer8_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;
  typedef struct packed {
    logic divider_out;
    logic pwm_out;
    logic match_irq;
  } pins_type;
endpackage : timer8_pkg

/* design/edge_sync.sv */
// two-stage synchroniser with falling-edge and rising-edge detection
`timescale 1ns/1ps
module edge_sync (
  input  wire logic MCLK_IN,
  input  wire logic RESETN_IN,
  input  wire logic async_in,
  output logic      level_out,
  output logic      fall_out,
  output logic      rise_out
);
  import timer8_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_state_type;
  sync_state_type st_r;
  sync_state_type st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  // start high so no phantom edge at release
  always_ff @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      st_r <= 3'h7;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.s2;
  assign fall_out  = st_r.s3 & ~st_r.s2;
  assign rise_out  = ~st_r.s3 & st_r.s2;
endmodule : edge_sync

/* design/timer8_event_divider_pwm.sv */
// 8-bit timer channel: event counter, divider output and pwm, apb slave
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "timer8_map.svh"

module timer8_event_divider_pwm #(
  parameter int PRE_WIDTH = 11
) (
  input  wire logic                     MCLK_IN,
  input  wire logic                     RESETN_IN,
  input  wire timer8_pkg::apb_req_type  APB_REQ_IN,
  output timer8_pkg::apb_rsp_type       APB_RSP_OUT,
  input  wire logic                     EVENT_INPUT_PIN_IN,
  input  wire logic                     SLOW_CLOCK_IN,
  output timer8_pkg::pins_type          PINS_OUT
);
  import timer8_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [9:0]           ctrl;
    logic [7:0]           cmp;
    logic [7:0]           duty_act;
    logic [7:0]           duty_buf;
    logic [7:0]           count;
    logic                 tff;
    logic                 match_flag;
    logic                 irq;
    logic [PRE_WIDTH-1:0] pre;
    logic [3:0]           slow_pre;
    logic [31:0]          rdata;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  logic       ev_fall;
  logic       slow_rise;
  logic       pre_tick;
  logic       tick;
  logic [1:0] mode;
  logic       run;
  logic [2:0] src;
  logic       wr_en;
  logic       rd_en;
  logic [9:0] wctrl;
  logic       match;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  edge_sync u_event_sync (
    .MCLK_IN   (MCLK_IN),
    .RESETN_IN (RESETN_IN),
    .async_in  (EVENT_INPUT_PIN_IN),
    .level_out (),
    .fall_out  (ev_fall),
    .rise_out  ()
  );

  // the slow clock is sampled as data, so it must be far below 200 MHz
  edge_sync u_slow_sync (
    .MCLK_IN   (MCLK_IN),
    .RESETN_IN (RESETN_IN),
    .async_in  (SLOW_CLOCK_IN),
    .level_out (),
    .fall_out  (),
    .rise_out  (slow_rise)
  );

  assign mode  = st_r.ctrl[`CTRL_MODE_LO +: 2];
  assign run   = st_r.ctrl[`CTRL_RUN_BIT];
  assign src   = st_r.ctrl[`CTRL_SRC_LO +: 3];
  assign wr_en = APB_REQ_IN.psel & APB_REQ_IN.penable & APB_REQ_IN.pwrite;
  assign rd_en = APB_REQ_IN.psel & ~APB_REQ_IN.penable & ~APB_REQ_IN.pwrite;
  assign wctrl = APB_REQ_IN.pwdata[9:0];

  // ----------------------------------------------------------------
  // source clock selection
  // ----------------------------------------------------------------
  always_comb begin
    pre_tick = 1'b0;
    case (src)
      `SRC_DIV2048: begin
        if (st_r.ctrl[`CTRL_PSEL_BIT] || st_r.ctrl[`CTRL_SLOW_BIT]) begin
          pre_tick = slow_rise &
                     (&st_r.slow_pre[`SLOW_TAP_8:0]);
        end else begin
          pre_tick = &st_r.pre[`PRE_TAP_2048:0];
        end
      end
      `SRC_DIV128:  pre_tick = &st_r.pre[`PRE_TAP_128:0];
      `SRC_DIV32:   pre_tick = &st_r.pre[`PRE_TAP_32:0];
      `SRC_DIV8:    pre_tick = &st_r.pre[`PRE_TAP_8:0];
      `SRC_SLOW:    pre_tick = slow_rise;
      `SRC_HALF:    pre_tick = st_r.pre[`PRE_TAP_HALF];
      `SRC_FAST:    pre_tick = 1'b1;
      default:      pre_tick = 1'b0;
    endcase
    // fast taps are unavailable in slow mode
    if (st_r.ctrl[`CTRL_SLOW_BIT] && src != `SRC_SLOW &&
        src != `SRC_DIV2048) begin
      pre_tick = 1'b0;
    end
  end

  always_comb begin
    case (mode)
      `MODE_EVENT: tick = run & ev_fall;
      `MODE_DIVIDER: tick = run & pre_tick;
      `MODE_PWM: tick = run & pre_tick;
      default: tick = 1'b0;
    endcase
  end

  assign match = (st_r.count == st_r.cmp);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.irq      = 1'b0;
    st_nxt.pre      = PRE_WIDTH'(st_r.pre + 1'b1);
    st_nxt.slow_pre = slow_rise ? 4'(st_r.slow_pre + 1'b1) : st_r.slow_pre;

    if (tick) begin
      case (mode)
        `MODE_EVENT: begin
          if (match) begin
            st_nxt.count = `COUNT_RESET;
            st_nxt.irq   = 1'b1;
          end else begin
            st_nxt.count = 8'(st_r.count + 1'b1);
          end
        end
        `MODE_DIVIDER: begin
          if (match) begin
            st_nxt.count = `COUNT_RESET;
            st_nxt.tff   = ~st_r.tff;
            st_nxt.irq   = 1'b1;
          end else begin
            st_nxt.count = 8'(st_r.count + 1'b1);
          end
        end
        `MODE_PWM: begin
          // toggle on duty match and overflow
          if (st_r.count == `COUNT_MAX) begin
            st_nxt.count    = `COUNT_RESET;
            st_nxt.tff      = ~st_r.tff;
            st_nxt.irq      = 1'b1;
            st_nxt.duty_act = st_r.duty_buf;
          end else begin
            st_nxt.count = 8'(st_r.count + 1'b1);
            if (st_r.count == st_r.duty_act) begin
              st_nxt.tff = ~st_r.tff;
            end
          end
        end
        default: st_nxt.count = st_r.count;
      endcase
    end

    if (!run && mode == `MODE_PWM) begin
      st_nxt.duty_act = st_r.duty_buf;
    end

    // writes, apb access phase
    if (wr_en) begin
      case (APB_REQ_IN.paddr)
        `CTRL_OFFSET: begin
          st_nxt.ctrl = wctrl;
          if (!run && !wctrl[`CTRL_RUN_BIT]) begin
            st_nxt.tff = wctrl[`CTRL_FF_BIT];
          end
          if (!wctrl[`CTRL_RUN_BIT]) begin
            st_nxt.count = `COUNT_RESET;
          end
        end
        `CMP_OFFSET:  st_nxt.cmp = APB_REQ_IN.pwdata[7:0];
        `DUTY_OFFSET: begin
          st_nxt.duty_buf = APB_REQ_IN.pwdata[7:0];
        end
        `STATUS_OFFSET: begin
          if (APB_REQ_IN.pwdata[`STAT_MATCH_BIT]) begin
            st_nxt.match_flag = 1'b0;
          end
        end
        default: st_nxt.ctrl = st_r.ctrl;
      endcase
    end
    // set wins over clear
    if (st_nxt.irq) begin
      st_nxt.match_flag = 1'b1;
    end

    // read data captured in setup phase
    if (rd_en) begin
      case (APB_REQ_IN.paddr)
        `CTRL_OFFSET: st_nxt.rdata = {22'h0, st_r.ctrl[9:8], st_r.tff,
                                       st_r.ctrl[6:0]};
        `CMP_OFFSET:  st_nxt.rdata = {24'h0, st_r.cmp};
        `DUTY_OFFSET: st_nxt.rdata = {24'h0, run ? st_r.duty_act
                                                 : st_r.duty_buf};
        `STATUS_OFFSET: st_nxt.rdata = {31'h0, st_r.match_flag};
        `COUNT_OFFSET:  st_nxt.rdata = {24'h0, st_r.count};
        default: st_nxt.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      st_r          <= '0;
      st_r.ctrl     <= `CTRL_RESET;
      st_r.cmp      <= `CMP_RESET;
      st_r.duty_act <= `DUTY_RESET;
      st_r.duty_buf <= `DUTY_RESET;
      st_r.tff      <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero-wait slave; unmapped addresses read zero with no error
  assign APB_RSP_OUT.pready  = 1'b1;
  assign APB_RSP_OUT.pslverr = 1'b0;
  assign APB_RSP_OUT.prdata  = st_r.rdata;

  assign PINS_OUT.divider_out = ~st_r.tff;
  assign PINS_OUT.pwm_out     = ~st_r.tff;
  assign PINS_OUT.match_irq   = st_r.irq;
endmodule : timer8_event_divider_pwm

/* tb/timer8_sva.sv */
// port checker for the timer channel
`timescale 1ns/1ps
`include "timer8_map.svh"
module timer8_sva (
  input wire logic                    MCLK_IN,
  input wire logic                    RESETN_IN,
  input wire timer8_pkg::apb_req_type APB_REQ_IN,
  input wire timer8_pkg::apb_rsp_type APB_RSP_OUT,
  input wire timer8_pkg::pins_type    PINS_OUT
);
  import timer8_pkg::*;
  // --------------------------------
  // control shadow and assertions
  // --------------------------------
  logic [9:0] ctrl_r;
  logic       ffw_r;
  logic       cw;
  assign cw = APB_REQ_IN.psel && APB_REQ_IN.penable && APB_REQ_IN.pwrite
    && APB_REQ_IN.paddr == `CTRL_OFFSET;
  always_ff @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      ctrl_r <= `CTRL_RESET;
      ffw_r  <= 1'b0;
    end else if (cw) begin
      ctrl_r <= APB_REQ_IN.pwdata[9:0];
      ffw_r  <= APB_REQ_IN.pwdata[`CTRL_FF_BIT];
    end
  end
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RESETN_IN);
  reset_out_a: assert property (
    disable iff (1'b0) !RESETN_IN |=> PINS_OUT.divider_out
    && !PINS_OUT.match_irq) else $error("pin level after reset");
  pins_equal_a: assert property (
    PINS_OUT.pwm_out == PINS_OUT.divider_out) else $error("pins differ");
  irq_pulse_a: assert property (
    PINS_OUT.match_irq |=> !PINS_OUT.match_irq) else $error("irq long");
  irq_run_a: assert property (
    PINS_OUT.match_irq |-> ctrl_r[3] || $past(ctrl_r[3])
    || $past(ctrl_r[3], 2)) else $error("irq while stopped");
  stop_hold_a: assert property (
    (!ctrl_r[3] || ctrl_r[1:0] == `MODE_EVENT) && !cw && !$past(cw)
    && !$past(cw, 2) |-> $stable(PINS_OUT.divider_out))
    else $error("pin moved while held");
  ff_load_a: assert property (
    cw && !APB_REQ_IN.pwdata[3] && !ctrl_r[3]
    |-> ##[1:3] PINS_OUT.divider_out == !ffw_r) else $error("ff not loaded");
  rsp_fixed_a: assert property (
    APB_RSP_OUT.pready && !APB_RSP_OUT.pslverr) else $error("bad response");
  rd_hold_a: assert property (
    !$past(APB_REQ_IN.psel && !APB_REQ_IN.penable && !APB_REQ_IN.pwrite)
    |-> $stable(APB_RSP_OUT.prdata)) else $error("read data moved");
endmodule : timer8_sva
bind timer8_event_divider_pwm timer8_sva chk_u (
  .MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN), .APB_REQ_IN(APB_REQ_IN),
  .APB_RSP_OUT(APB_RSP_OUT), .PINS_OUT(PINS_OUT));

/* tb/timer8_pulse_src.sv */
// event pulse source and free-running slow clock
`timescale 1ns/1ps
module timer8_pulse_src (
  input  wire logic mclk_in,
  output logic      event_out,
  output logic      slow_out
);
  // --------------------------------
  // pulse and clock generation
  // --------------------------------
  int div_r = 0;
  initial begin
    event_out = 1'b1;
    slow_out  = 1'b0;
  end
  // slow oscillator runs free, unrelated to bus traffic
  always @(posedge mclk_in) begin
    div_r <= (div_r == 6) ? 0 : div_r + 1;
    if (div_r == 6) slow_out <= ~slow_out;
  end
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge mclk_in) event_out <= 1'b0;
      repeat (4) @(posedge mclk_in);
      event_out <= 1'b1;
      repeat (4) @(posedge mclk_in);
    end
  endtask : pulses
endmodule : timer8_pulse_src

/* tb/timer8_event_divider_pwm_bench.sv */
// bench for the timer channel
`timescale 1ns/1ps
`include "timer8_map.svh"
module timer8_event_divider_pwm_bench;
  import timer8_pkg::*;
  // --------------------------------
  // signals, tasks and sequence
  // --------------------------------
  logic        clk;
  logic        rst_n;
  apb_req_type req;
  apb_rsp_type rsp;
  pins_type    pins;
  logic        ev;
  logic        slow;
  logic        lvl;
  logic [31:0] rd;
  int          failures = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          irqs = 0;
  int          t0, t1, l0, l1, n0;
  logic [11:0] offs[6] = '{`CTRL_OFFSET, `CMP_OFFSET, `DUTY_OFFSET,
    `STATUS_OFFSET, `COUNT_OFFSET, 12'h020};
  logic [2:0]  srcs[3] = '{`SRC_FAST, `SRC_HALF, `SRC_DIV8};
  int          pers[3] = '{256, 512, 2048};
  timer8_event_divider_pwm dut_u (
    .MCLK_IN(clk), .RESETN_IN(rst_n), .APB_REQ_IN(req), .APB_RSP_OUT(rsp),
    .EVENT_INPUT_PIN_IN(ev), .SLOW_CLOCK_IN(slow), .PINS_OUT(pins));
  timer8_pulse_src src_u (.mclk_in(clk), .event_out(ev), .slow_out(slow));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pins.match_irq === 1'b1) irqs <= irqs + 1;
  end
  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int k;
    @(posedge clk) req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk) req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    rd = rsp.prdata;
    req <= '{1'b0, 1'b0, w, a, d};
    if (k >= 20) begin
      failures++;
      stop_test();
    end
  endtask : apb
  task automatic wirq(output int t, output int lows);
    int k;
    k = 0;
    lows = 0;
    do begin
      @(posedge clk);
      k++;
      if (pins.pwm_out === 1'b0) lows++;
    end while (pins.match_irq !== 1'b1 && k < 5000);
    if (k >= 5000) begin
      failures++;
      stop_test();
    end
    t = cyc;
  endtask : wirq
  function automatic logic [31:0] cv(input logic [1:0] m, input logic r,
      input logic [2:0] s, input logic f);
    return 32'(m) << `CTRL_MODE_LO | 32'(r) << `CTRL_RUN_BIT
      | 32'(s) << `CTRL_SRC_LO | 32'(f) << `CTRL_FF_BIT;
  endfunction : cv
  initial begin
    rst_n = 1'b0;
    req = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    chk("div pin", 32'h1, 32'(pins.divider_out));
    foreach (offs[i]) begin
      apb(0, offs[i], 0);
      chk("reset read", 0, rd);
    end
    apb(1, `CMP_OFFSET, 32'h3);
    apb(1, `CTRL_OFFSET, cv(`MODE_EVENT, 1, 0, 0));
    n0 = irqs;
    src_u.pulses(4);
    repeat (6) @(posedge clk);
    chk("event irqs", 1, irqs - n0);
    apb(0, `STATUS_OFFSET, 0);
    chk("match flag", 1, rd);
    apb(1, `STATUS_OFFSET, 32'h1);
    apb(0, `STATUS_OFFSET, 0);
    chk("flag clear", 0, rd);
    src_u.pulses(2);
    repeat (6) @(posedge clk);
    apb(0, `COUNT_OFFSET, 0);
    chk("event count", 2, rd);
    apb(1, `CMP_OFFSET, 32'h4);
    src_u.pulses(2);
    repeat (6) @(posedge clk);
    apb(0, `COUNT_OFFSET, 0);
    chk("new compare", 4, rd);
    apb(1, `CTRL_OFFSET, cv(`MODE_EVENT, 0, 0, 0));
    apb(1, `CTRL_OFFSET, cv(`MODE_DIVIDER, 1, `SRC_FAST, 0));
    wirq(t0, l0);
    repeat (2) @(posedge clk);
    lvl = pins.divider_out;
    wirq(t1, l1);
    chk("div period", 5, t1 - t0);
    repeat (2) @(posedge clk);
    chk("div toggle", 32'(!lvl), 32'(pins.divider_out));
    apb(1, `CTRL_OFFSET, cv(`MODE_DIVIDER, 0, `SRC_FAST, 0));
    lvl = pins.divider_out;
    repeat (20) @(posedge clk);
    chk("stop hold", 32'(lvl), 32'(pins.divider_out));
    apb(1, `CTRL_OFFSET, cv(`MODE_DIVIDER, 0, `SRC_FAST, 1));
    repeat (3) @(posedge clk);
    chk("ff one", 0, 32'(pins.divider_out));
    apb(1, `CTRL_OFFSET, cv(`MODE_PWM, 0, `SRC_FAST, 0));
    repeat (3) @(posedge clk);
    chk("ff zero", 1, 32'(pins.pwm_out));
    apb(1, `DUTY_OFFSET, 32'h10);
    apb(0, `DUTY_OFFSET, 0);
    chk("duty stopped", 32'h10, rd);
    apb(1, `CTRL_OFFSET, cv(`MODE_PWM, 1, `SRC_FAST, 0));
    wirq(t0, l0);
    apb(1, `DUTY_OFFSET, 32'h30);
    apb(0, `DUTY_OFFSET, 0);
    chk("duty old", 32'h10, rd);
    wirq(t0, l0);
    apb(0, `DUTY_OFFSET, 0);
    chk("duty new", 32'h30, rd);
    wirq(t1, l1);
    chk("pwm low", 32'h20, l0 - l1);
    foreach (srcs[i]) begin
      apb(1, `CTRL_OFFSET, cv(`MODE_PWM, 0, srcs[i], 0));
      apb(1, `CTRL_OFFSET, cv(`MODE_PWM, 1, srcs[i], 0));
      wirq(t0, l0);
      wirq(t1, l1);
      chk("pwm period", pers[i], t1 - t0);
    end
    apb(1, `CTRL_OFFSET, cv(`MODE_PWM, 0, `SRC_FAST, 0));
    apb(0, `CTRL_OFFSET, 0);
    chk("stopped", 0, 32'(rd[`CTRL_RUN_BIT]));
    stop_test();
  end
endmodule : timer8_event_divider_pwm_bench
